/* File: verilog/gate_select_pkg.sv */
package gate_select_pkg;

  // Register byte addresses on the Wishbone bus
  localparam logic [3:0] SEL0_ADDR       = 4'h0;
  localparam logic [3:0] SEL1_ADDR       = 4'h4;
  localparam logic [3:0] SEL2_ADDR       = 4'h8;
  localparam logic [3:0] SEL3_ADDR       = 4'hC;
  localparam logic [3:0] GATE1_SEL_ADDR  = 4'h0;
  localparam logic [3:0] GATE2_SEL_ADDR  = 4'h4;
  localparam logic [3:0] STATUS_ADDR     = 4'h8;
  localparam logic [4:0] BANK_GATE_ADDR  = 5'h10;

  // Field layout
  localparam int SRC_W      = 6;
  localparam int SRC_COUNT  = 64;
  localparam int SEL_COUNT  = 4;
  localparam int GSEL_W     = 8;

  // Reset values
  localparam logic [5:0] SRC_SEL_RST  = 6'h00;
  localparam logic [7:0] GATE_SEL_RST = 8'h00;

  // Gate output when nothing is enabled
  localparam logic GATE_IDLE = 1'b0;

endpackage

/* File: verilog/data_selector.sv */
`timescale 1ns/1ps
module data_selector
  import gate_select_pkg::*;
(
  // Selection
  input  wire logic [SRC_W-1:0]     srcSel,
  input  wire logic [SRC_COUNT-1:0] srcBus,
  // Outputs
  output logic                      outTrue,
  output logic                      outInv
);

  wire picked = srcBus[srcSel];

  assign outTrue = picked;
  assign outInv  = ~picked;

endmodule

/* File: verilog/gate_or.sv */
`timescale 1ns/1ps
module gate_or
  import gate_select_pkg::*;
(
  // Enables, true/inverted pairs interleaved as in the select register
  input  wire logic [GSEL_W-1:0] enables,
  // Selector outputs
  input  wire logic [SEL_COUNT-1:0] selTrue,
  input  wire logic [SEL_COUNT-1:0] selInv,
  // Result
  output logic                      gateOut
);

  logic [GSEL_W-1:0] terms;

  genvar i;
  generate
    for (i = 0; i < SEL_COUNT; i = i + 1) begin : g_term
      assign terms[2*i+1] = enables[2*i+1] & selTrue[i];
      assign terms[2*i]   = enables[2*i] & selInv[i];
    end
  endgenerate

  assign gateOut = (|terms) | GATE_IDLE;

endmodule

/* File: verilog/logic_cell_gate_input_select.sv */
// Contract
// - Gate 1 select bit 1 routes the true selector 1 output into gate 1, else excludes it.
// - Gate 2 select bit 7 routes the true selector 4 output into gate 2, else excludes it.
// - Gate 2 select bit 6 routes the inverted selector 4 output into gate 2, else excludes it.
// - Each negated select bit steers the complement of its selector output, independent of the true bit.
// - Each true select bit steers its selector output uninverted, as a separate control.
// - Each selector output is chosen from the cell inputs by a six-bit selection field.
`timescale 1ns/1ps
module logic_cell_gate_input_select
  import gate_select_pkg::*;
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 srst,
  // Wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [4:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      wb_err_o,
  // Cell inputs
  input  wire logic [SRC_COUNT-1:0] cellInputs,
  // Gate outputs
  output logic                      gate_one_out,
  output logic                      gate_two_out
);

  logic [SRC_W-1:0]     srcSel_ff [SEL_COUNT];
  logic [GSEL_W-1:0]    gate1_input_select_ff;
  logic [GSEL_W-1:0]    gate2_input_select_ff;
  logic                 ack_ff;
  logic                 err_ff;
  logic [31:0]          rdat_ff;
  logic                 gateOne_ff;
  logic                 gateTwo_ff;
  logic [SEL_COUNT-1:0] selTrue;
  logic [SEL_COUNT-1:0] selInv;
  logic                 gateOneComb;
  logic                 gateTwoComb;

  // Bus decode: bank 0 holds source selects, bank 1 the gate selects
  wire       req       = wb_cyc_i & wb_stb_i & ~ack_ff & ~err_ff;
  wire       bankGate  = wb_adr_i[4];
  wire [3:0] low       = wb_adr_i[3:0];
  wire       aligned   = (wb_adr_i[1:0] == 2'h0);
  wire       hitSrc    = ~bankGate & aligned;
  wire       hitG1     = bankGate & (low == GATE1_SEL_ADDR);
  wire       hitG2     = bankGate & (low == GATE2_SEL_ADDR);
  wire       hitStat   = bankGate & (low == STATUS_ADDR);
  wire       hitAny    = hitSrc | hitG1 | hitG2 | hitStat;
  wire       wrLane0   = req & wb_we_i & wb_sel_i[0];
  wire [1:0] srcIdx    = wb_adr_i[3:2];

  wire [GSEL_W-1:0] nxt_gate1 = (wrLane0 & hitG1) ? wb_dat_i[7:0] : gate1_input_select_ff;
  wire [GSEL_W-1:0] nxt_gate2 = (wrLane0 & hitG2) ? wb_dat_i[7:0] : gate2_input_select_ff;

  wire [31:0] srcRead   = {26'h0, srcSel_ff[srcIdx]};
  wire [31:0] g1Read    = {24'h000000, gate1_input_select_ff};
  wire [31:0] g2Read    = {24'h000000, gate2_input_select_ff};
  wire [31:0] statRead  = {30'h0, gateTwo_ff, gateOne_ff};
  wire [31:0] nxt_rdat  = hitSrc  ? srcRead :
                          hitG1   ? g1Read  :
                          hitG2   ? g2Read  :
                          hitStat ? statRead : 32'h00000000;

  // Source select registers, one per data selector
  genvar k;
  generate
    for (k = 0; k < SEL_COUNT; k = k + 1) begin : g_src
      wire wrThis = wrLane0 & hitSrc & (srcIdx == 2'(k));
      always_ff @(posedge ref_clk) begin
        if (srst) begin
          srcSel_ff[k] <= SRC_SEL_RST;
        end else if (wrThis) begin
          srcSel_ff[k] <= wb_dat_i[SRC_W-1:0];
        end
      end
      data_selector u_sel (
        .srcSel  (srcSel_ff[k]),
        .srcBus  (cellInputs),
        .outTrue (selTrue[k]),
        .outInv  (selInv[k])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gate1_input_select_ff <= GATE_SEL_RST;
      gate2_input_select_ff <= GATE_SEL_RST;
      ack_ff                <= 1'b0;
      err_ff                <= 1'b0;
      rdat_ff               <= 32'h00000000;
    end else begin
      gate1_input_select_ff <= nxt_gate1;
      gate2_input_select_ff <= nxt_gate2;
      ack_ff                <= req & hitAny;
      err_ff                <= req & ~hitAny;
      rdat_ff               <= (req & ~wb_we_i) ? nxt_rdat : rdat_ff;
    end
  end

  // bit 1 true sel1, bit 3 true sel2, per pair
  gate_or u_gate1 (
    .enables (gate1_input_select_ff),
    .selTrue (selTrue),
    .selInv  (selInv),
    .gateOut (gateOneComb)
  );

  // bit 7 true sel4, bit 6 inverted sel4
  gate_or u_gate2 (
    .enables (gate2_input_select_ff),
    .selTrue (selTrue),
    .selInv  (selInv),
    .gateOut (gateTwoComb)
  );

  // Gate outputs registered so the data outputs are glitch-free
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      gateOne_ff <= GATE_IDLE;
      gateTwo_ff <= GATE_IDLE;
    end else begin
      gateOne_ff <= gateOneComb;
      gateTwo_ff <= gateTwoComb;
    end
  end

  assign gate_one_out = gateOne_ff;
  assign gate_two_out = gateTwo_ff;
  assign wb_dat_o     = rdat_ff;
  assign wb_ack_o     = ack_ff;
  assign wb_err_o     = err_ff;

endmodule

/* File: bench/logic_cell_gate_input_select_props.sv */
`timescale 1ns/1ps
module logic_cell_gate_input_select_props (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       srst,
  // Wishbone
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [4:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic       wb_ack_o,
  input wire logic       wb_err_o,
  // Gates
  input wire logic       gate_one_out,
  input wire logic       gate_two_out
);
  logic armed_ff;
  wire  take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  logic [7:0] g1Sh_ff;
  logic [7:0] g2Sh_ff;
  wire  wrLow   = take && wb_we_i && wb_sel_i[0];
  wire  g1Empty = (g1Sh_ff == 8'h00);
  wire  g2Empty = (g2Sh_ff == 8'h00);
  wire  g2Both  = g2Sh_ff[7] && g2Sh_ff[6];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Set on the taking edge, since the gate can move one edge later
  always_ff @(posedge ref_clk) armed_ff <= !srst && (armed_ff || (take && wb_we_i && wb_adr_i[4]));
  // Shadow of the gate selects, written on the taking edge like the block itself
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      g1Sh_ff <= 8'h00;
      g2Sh_ff <= 8'h00;
    end else begin
      if (wrLow && wb_adr_i == 5'h10) begin
        g1Sh_ff <= wb_dat_i[7:0];
      end
      if (wrLow && wb_adr_i == 5'h14) begin
        g2Sh_ff <= wb_dat_i[7:0];
      end
    end
  end
  property p_answer;
    take |=> (wb_ack_o ^ wb_err_o) ##1 !(wb_ack_o || wb_err_o);
  endproperty
  a_answer: assert property (p_answer) else $error("no single answer pulse");
  property p_unmapped;
    take && wb_adr_i >= 5'h1C |=> wb_err_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  property p_mapped;
    take && wb_adr_i < 5'h18 && wb_adr_i[1:0] == 2'h0 |=> wb_ack_o;
  endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access not acked");
  property p_idle;
    !armed_ff |-> !gate_one_out && !gate_two_out;
  endproperty
  a_idle: assert property (p_idle) else $error("gate active with no enables");
  // Gate output lags its select register by one edge
  property p_g1_empty;
    $past(g1Empty) |-> !gate_one_out;
  endproperty
  a_g1_empty: assert property (p_g1_empty) else $error("gate 1 high with empty select");
  property p_g2_empty;
    $past(g2Empty) |-> !gate_two_out;
  endproperty
  a_g2_empty: assert property (p_g2_empty) else $error("gate 2 high with empty select");
  property p_sel4_pair;
    $past(g2Both) |-> gate_two_out;
  endproperty
  a_sel4_pair: assert property (p_sel4_pair) else $error("gate 2 low with both selector 4 forms");
endmodule

/* File: bench/tb_logic_cell_gate_input_select.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin checkCount++; if ((g) !== (e)) begin nFail++; $display("wrong value at %0t: %h", $time, g); end end
module tb_logic_cell_gate_input_select;
  import gate_select_pkg::*;
  logic        ref_clk = 0, srst = 1, cyc = 0, stb = 0, we = 0, err, ack, g1, g2;
  logic [4:0]  adr = 0;
  logic [31:0] wdat = 0, rdo, rdat;
  logic [63:0] cells = 0;
  logic [3:0]  sel = 4'h0, laneMask = 4'hF;
  int          nFail = 0, checkCount = 0;
  always #10 ref_clk = ~ref_clk;
  logic_cell_gate_input_select i_logic_cell_gate_input_select (.ref_clk(ref_clk), .srst(srst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdo),
    .wb_ack_o(ack), .wb_err_o(err), .cellInputs(cells), .gate_one_out(g1), .gate_two_out(g2));
  task automatic wrap_up;
    if (nFail == 0 && checkCount > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d, input logic e);
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    sel <= laneMask;
    do @(posedge ref_clk); while (!ack && !err);
    rdat = rdo;
    `CHK(err, e)
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Gate path is one register stage behind the inputs
  task automatic gchk(input logic [63:0] v, input logic e1, input logic e2);
    @(posedge ref_clk);
    cells <= v;
    repeat (2) @(posedge ref_clk);
    `CHK({g1, g2}, {e1, e2})
  endtask
  initial begin
    repeat (2000) @(posedge ref_clk);
    nFail++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    bus(5'h10, 1'b0, 8'h0, 1'b0);
    `CHK(rdat, 32'h0)
    bus(5'h00, 1'b1, 8'hE5, 1'b0);
    bus(5'h00, 1'b0, 8'h0, 1'b0);
    `CHK(rdat, 32'h25)
    bus(5'h1C, 1'b1, 8'hFF, 1'b1);
    gchk(64'hF, 1'b0, 1'b0);
    // One enable at a time, each input level
    for (int b = 0; b < 16; b++) begin
      bus(5'h10, 1'b1, b < 8 ? 8'h1 << b : 8'h0, 1'b0);
      bus(5'h14, 1'b1, b < 8 ? 8'h0 : 8'h1 << (b - 8), 1'b0);
      for (int v = 0; v < 2; v++) begin
        gchk({64{v[0]}}, b < 8 && b[0] == v[0], b > 7 && b[0] == v[0]);
      end
    end
    bus(5'h10, 1'b1, 8'h02, 1'b0);
    bus(5'h14, 1'b1, 8'hC0, 1'b0);
    gchk(64'h1 << 37, 1'b1, 1'b1);
    gchk(~(64'h1 << 37), 1'b0, 1'b1);
    bus(5'h18, 1'b0, 8'h0, 1'b0);
    `CHK(rdat, 32'h2)
    // Lane 0 off: acked but nothing may be written
    laneMask = 4'hE;
    bus(5'h10, 1'b1, 8'hFF, 1'b0);
    laneMask = 4'hF;
    bus(5'h10, 1'b0, 8'h0, 1'b0);
    `CHK(rdat, 32'h2)
    wrap_up();
  end
endmodule
bind logic_cell_gate_input_select logic_cell_gate_input_select_props i_logic_cell_gate_input_select_props (
  .ref_clk(ref_clk), .srst(srst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .gate_one_out(gate_one_out),
  .gate_two_out(gate_two_out));
